// *** shared/swbs_cfg.svh ***
// Constants for the standby, wake and boot sequencer
`ifndef SWBS_CFG_SVH
`define SWBS_CFG_SVH

`define SWBS_CLK_MHZ 100
`define SWBS_GPIO_W 9
`define SWBS_RRAM_BYTES 8
`define SWBS_RRAM_AW 3
`define SWBS_CODE_KB 4
`define SWBS_CODE_AW 12
`define SWBS_BOOT_FIXED_US 2000
`define SWBS_BOOT_PER_KB_US 3600
`define SWBS_BOOT_FIXED_CYC (`SWBS_BOOT_FIXED_US * `SWBS_CLK_MHZ)
`define SWBS_BOOT_PER_KB_CYC (`SWBS_BOOT_PER_KB_US * `SWBS_CLK_MHZ)
`define SWBS_KB_BYTES 1024
`define SWBS_DIV_MAX_LOG2 7
`define SWBS_DIV_SEL_W 3
`define SWBS_NUM_PERIPH 8
`define SWBS_FCNT_W 24
`define SWBS_SLEEP_W 32

`endif

// *** shared/swbs_pkg.sv ***
// Types for the standby, wake and boot sequencer
package swbs_pkg;
	typedef enum logic [2:0] {
		SWBS_POR,
		SWBS_STANDBY,
		SWBS_BOOT_FIXED,
		SWBS_BOOT_COPY,
		SWBS_RUN
	} swbs_state_e;

	typedef struct packed {
		logic req;
		logic [11:0] addr;
	} swbs_otp_req_s;

	typedef struct packed {
		logic we;
		logic [11:0] addr;
		logic [7:0] data;
	} swbs_code_wr_s;

	typedef struct packed {
		logic lp_osc_en;
		logic xtal_en;
		logic carrier_en;
		logic divider_en;
		logic pa_en;
		logic bandgap_en;
		logic rtc_tmr_clk_en;
	} swbs_power_s;
endpackage

// *** hdl/swbs_sequencer.sv ***
// Standby, wake and boot-copy sequencer with clock and power policy
`timescale 1ns/100ps
`include "swbs_cfg.svh"

// Behaviour
// (RL1) After power-up go straight to standby; run no program.
// (RL2) In standby power everything down except the 8-byte retained RAM.
// (RL3) A falling edge on any general-purpose pin wakes from standby.
// (RL4) A sleep-timer expiry also wakes the device periodically.
// (RL5) On wake, copy one-time memory into the 4 kB code RAM.
// (RL6) Copy runs on every wake; lasts 2 ms plus 3.6 ms per kB.
// (RL7) MCU runs from RAM only after the copy finishes.
// (RL8) The 24 MHz low-power oscillator clocks the MCU; off only in standby. The boot cycle counts here assume a 100 MHz clock.
// (RL9) System clock divides the oscillator by a power of two up to 128.
// (RL10) Real-time clock and timers two and three use the low-power oscillator.
// (RL11) Crystal, if enabled, runs only before transmission, then shuts down.
// (RL12) A frequency counter measures ratios between clock sources.
// (RL13) Power-on reset puts the whole chip in a known state.
// (RL14) Software may shut down any single peripheral or all of them.
// (RL15) Serializer schedules carrier, divider and amplifier power during transmit.
// (RL16) Bandgap may be shut down while analog blocks are unused.
// (RL17) MCU held in reset from wake until copy ends; wake ignored meanwhile.
module swbs_sequencer
	import swbs_pkg::*;
#(
	parameter int unsigned BOOT_FIXED_CYC = `SWBS_BOOT_FIXED_CYC,
	parameter int unsigned BOOT_PER_KB_CYC = `SWBS_BOOT_PER_KB_CYC,
	parameter int unsigned BOOT_KB = `SWBS_CODE_KB
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [`SWBS_GPIO_W-1:0] gpio_in,
	input wire logic [`SWBS_SLEEP_W-1:0] sleep_period,
	input wire logic sleep_enable,
	input wire logic standby_req,
	input wire logic [7:0] otp_data,
	input wire logic [`SWBS_DIV_SEL_W-1:0] sysclk_div_sel,
	input wire logic xtal_use,
	input wire logic tx_prepare,
	input wire logic serializer_carrier_on,
	input wire logic serializer_divider_on,
	input wire logic serializer_pa_on,
	input wire logic analog_in_use,
	input wire logic [`SWBS_NUM_PERIPH-1:0] periph_shutdown,
	input wire logic shutdown_all,
	input wire logic fcnt_start,
	input wire logic fcnt_ref_tick,
	input wire logic fcnt_meas_tick,
	input wire logic [15:0] fcnt_ref_len,
	input wire logic rram_we,
	input wire logic [`SWBS_RRAM_AW-1:0] rram_addr,
	input wire logic [7:0] rram_wdata,
	output logic [7:0] rram_rdata,
	output swbs_otp_req_s otp_req,
	output swbs_code_wr_s code_wr,
	output logic mcu_reset_n,
	output logic boot_busy,
	output logic in_standby,
	output logic sysclk_tick,
	output swbs_power_s power,
	output logic [`SWBS_NUM_PERIPH-1:0] periph_en,
	output logic [`SWBS_FCNT_W-1:0] fcnt_result,
	output logic fcnt_done
);
	typedef struct packed {
		swbs_state_e st;
		logic [`SWBS_GPIO_W-1:0] gpio_prev;
		logic [`SWBS_SLEEP_W-1:0] sleep_cnt;
		logic [31:0] boot_cnt;
		logic [11:0] copy_addr;
		logic rd_pending;
		logic [11:0] rd_addr;
		logic [7:0] div_cnt;
		logic sys_tick;
		swbs_otp_req_s otp;
		swbs_code_wr_s wr;
		logic xtal_on;
		logic fc_run;
		logic [15:0] fc_ref;
		logic [`SWBS_FCNT_W-1:0] fc_meas;
		logic [`SWBS_FCNT_W-1:0] fc_res;
		logic fc_done;
	} swbs_core_s;

	localparam logic [31:0] PER_BYTE_CYC = 32'(BOOT_PER_KB_CYC / `SWBS_KB_BYTES);
	localparam logic [11:0] LAST_ADDR = 12'(BOOT_KB * `SWBS_KB_BYTES - 1);
	localparam logic [31:0] FIXED_LAST = 32'(BOOT_FIXED_CYC - 1);

	swbs_core_s r;
	swbs_core_s next_r;
	logic [7:0] rram [`SWBS_RRAM_BYTES];
	logic wake_pin;
	logic wake_timer;
	logic [7:0] div_last;
	logic active;

	// Retained RAM keeps contents through standby; only power-on reset clears it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < `SWBS_RRAM_BYTES; i++) begin
				rram[i] <= 8'h00;
			end
		end else if (rram_we && r.st == SWBS_RUN) begin
			rram[rram_addr] <= rram_wdata; // RL2
		end
	end

	always_comb begin
		wake_pin = |(r.gpio_prev & ~gpio_in); // RL3
		wake_timer = sleep_enable && (sleep_period != 32'h0000_0000) && (r.sleep_cnt >= sleep_period - 32'h0000_0001); // RL4
		div_last = 8'((9'h001 << sysclk_div_sel) - 9'h001); // RL9
		active = (r.st != SWBS_POR) && (r.st != SWBS_STANDBY);
	end

	always_comb begin
		next_r = r;
		next_r.gpio_prev = gpio_in;
		next_r.otp.req = 1'b0;
		next_r.wr.we = 1'b0;
		next_r.sys_tick = 1'b0;
		next_r.fc_done = 1'b0;
		case (r.st)
			SWBS_POR: begin
				next_r.st = SWBS_STANDBY; // RL1
				next_r.sleep_cnt = 32'h0000_0000;
			end
			SWBS_STANDBY: begin
				next_r.sleep_cnt = sleep_enable ? r.sleep_cnt + 32'h0000_0001 : 32'h0000_0000;
				if (wake_pin || wake_timer) begin
					next_r.st = SWBS_BOOT_FIXED; // RL3 RL4 RL17
					next_r.sleep_cnt = 32'h0000_0000;
					next_r.boot_cnt = 32'h0000_0000;
					next_r.copy_addr = 12'h000;
					next_r.rd_pending = 1'b0;
				end
			end
			SWBS_BOOT_FIXED: begin
				next_r.boot_cnt = r.boot_cnt + 32'h0000_0001; // RL6
				if (r.boot_cnt >= FIXED_LAST) begin
					next_r.st = SWBS_BOOT_COPY;
					next_r.boot_cnt = 32'h0000_0000;
				end
			end
			SWBS_BOOT_COPY: begin
				// One byte per pacing slot keeps the copy at 3.6 ms per kB
				next_r.boot_cnt = r.boot_cnt + 32'h0000_0001; // RL6
				if (r.boot_cnt == 32'h0000_0000) begin
					next_r.otp.req = 1'b1; // RL5
					next_r.otp.addr = r.copy_addr;
					next_r.rd_addr = r.copy_addr;
					next_r.rd_pending = 1'b1;
				end
				if (r.rd_pending && r.otp.req == 1'b0) begin
					next_r.wr.we = 1'b1; // RL5
					next_r.wr.addr = r.rd_addr;
					next_r.wr.data = otp_data;
					next_r.rd_pending = 1'b0;
				end
				if (r.boot_cnt >= PER_BYTE_CYC - 32'h0000_0001) begin
					next_r.boot_cnt = 32'h0000_0000;
					if (r.copy_addr == LAST_ADDR) begin
						next_r.st = SWBS_RUN; // RL7 RL17
					end else begin
						next_r.copy_addr = r.copy_addr + 12'h001;
					end
				end
			end
			SWBS_RUN: begin
				if (standby_req) begin
					next_r.st = SWBS_STANDBY; // RL2
					next_r.sleep_cnt = 32'h0000_0000;
				end
			end
			default: begin
				next_r.st = SWBS_STANDBY;
			end
		endcase

		// System clock tick from the low-power oscillator divider
		if (r.st == SWBS_RUN) begin
			if (r.div_cnt >= div_last) begin
				next_r.div_cnt = 8'h00;
				next_r.sys_tick = 1'b1; // RL9
			end else begin
				next_r.div_cnt = r.div_cnt + 8'h01;
			end
		end else begin
			next_r.div_cnt = 8'h00;
		end

		// Crystal runs only while preparing a transmission
		next_r.xtal_on = (r.st == SWBS_RUN) && xtal_use && tx_prepare; // RL11

		// Counts measured edges over a fixed number of reference edges
		if (r.st != SWBS_RUN) begin
			next_r.fc_run = 1'b0;
		end else if (fcnt_start && !r.fc_run) begin
			next_r.fc_run = 1'b1; // RL12
			next_r.fc_ref = 16'h0000;
			next_r.fc_meas = '0;
		end else if (r.fc_run) begin
			if (fcnt_meas_tick) begin
				next_r.fc_meas = r.fc_meas + 24'h00_0001;
			end
			if (fcnt_ref_tick) begin
				next_r.fc_ref = r.fc_ref + 16'h0001;
				if (r.fc_ref + 16'h0001 >= fcnt_ref_len) begin
					next_r.fc_run = 1'b0; // RL12
					next_r.fc_done = 1'b1;
					next_r.fc_res = fcnt_meas_tick ? r.fc_meas + 24'h00_0001 : r.fc_meas;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '{st: SWBS_POR, default: '0}; // RL13
		end else begin
			r <= next_r;
		end
	end

	always_comb begin
		rram_rdata = rram[rram_addr];
		otp_req = r.otp;
		code_wr = r.wr;
		mcu_reset_n = (r.st == SWBS_RUN); // RL7 RL17
		boot_busy = (r.st == SWBS_BOOT_FIXED) || (r.st == SWBS_BOOT_COPY);
		in_standby = (r.st == SWBS_STANDBY) || (r.st == SWBS_POR); // RL2
		sysclk_tick = r.sys_tick;
		power.lp_osc_en = active; // RL8
		power.rtc_tmr_clk_en = (r.st == SWBS_RUN); // RL10
		// Registered crystal request lags the state by one edge; gate it so standby stays dark
		power.xtal_en = r.xtal_on && (r.st == SWBS_RUN); // RL11 RL2
		power.carrier_en = (r.st == SWBS_RUN) && (serializer_carrier_on || r.xtal_on); // RL15
		power.divider_en = (r.st == SWBS_RUN) && serializer_divider_on; // RL15
		power.pa_en = (r.st == SWBS_RUN) && serializer_pa_on; // RL15
		power.bandgap_en = active && (analog_in_use || boot_busy); // RL16
		fcnt_result = r.fc_res;
		fcnt_done = r.fc_done;
	end

	generate
		for (genvar g = 0; g < `SWBS_NUM_PERIPH; g++) begin : g_periph
			assign periph_en[g] = (r.st == SWBS_RUN) && !shutdown_all && !periph_shutdown[g]; // RL14
		end
	endgenerate
endmodule

// *** sim/swbs_otp_model.sv ***
// One-time memory model answering the boot copy fetches
`timescale 1ns/100ps
module swbs_otp_model
	import swbs_pkg::*;
(
	input wire logic clk,
	input wire swbs_otp_req_s otp_req,
	output logic [7:0] otp_data
);
	logic [7:0] held = 8'h00;
	logic hold_v = 1'b0;
	// Byte stands in the fetch cycle and the next, then turns to its inverse
	assign otp_data = otp_req.req ? (otp_req.addr[7:0] ^ otp_req.addr[11:4] ^ 8'h3c) : (hold_v ? held : ~held);
	always @(posedge clk) begin
		hold_v <= otp_req.req;
		if (otp_req.req) held <= otp_data;
	end
endmodule

// *** sim/swbs_asserts.sv ***
// Property checker for the standby wake boot sequencer
`timescale 1ns/100ps
module swbs_checker
	import swbs_pkg::*;
#(
	parameter int unsigned BOOT_FIXED_CYC = 20,
	parameter int unsigned BOOT_PER_KB_CYC = 4096,
	parameter int unsigned BOOT_KB = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [8:0] gpio_in,
	input wire logic standby_req,
	input wire logic [7:0] periph_shutdown,
	input wire logic shutdown_all,
	input wire swbs_otp_req_s otp_req,
	input wire swbs_code_wr_s code_wr,
	input wire logic mcu_reset_n,
	input wire logic boot_busy,
	input wire logic in_standby,
	input wire swbs_power_s power,
	input wire logic [7:0] periph_en
);
	localparam int boot_len = BOOT_FIXED_CYC + BOOT_KB * BOOT_PER_KB_CYC;
	int busy_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) busy_cnt <= 0;
		else busy_cnt <= boot_busy ? busy_cnt + 1 : 0;
	end
	sequence s_fetch;
		otp_req.req;
	endsequence
	sequence s_store;
		code_wr.we && code_wr.addr == $past(otp_req.addr, 2);
	endsequence
	a_fetch_then_store: assert property (s_fetch |-> ##2 s_store)
		else $error("store does not follow fetch");
	a_boot_length: assert property ($fell(boot_busy) |-> busy_cnt >= boot_len - 2 && busy_cnt <= boot_len + 2)
		else $error("boot length off");
	a_run_after_boot: assert property (mcu_reset_n |-> !boot_busy && !in_standby)
		else $error("core runs during boot or standby");
	a_standby_dark: assert property (in_standby |-> power == '0 && periph_en == '0)
		else $error("power on in standby");
	a_boot_osc_on: assert property (boot_busy |-> power.lp_osc_en && !mcu_reset_n)
		else $error("boot without oscillator or core free");
	a_pin_wake: assert property ($past(rstn, 2) && in_standby && |($past(gpio_in) & ~gpio_in) |=> boot_busy)
		else $error("pin fall missed");
	a_enter_standby: assert property (mcu_reset_n && standby_req |=> in_standby && !mcu_reset_n)
		else $error("standby not entered");
	a_periph_gate: assert property (mcu_reset_n && $stable(periph_shutdown) && $stable(shutdown_all)
		|-> (periph_en & (periph_shutdown | {8{shutdown_all}})) == '0)
		else $error("peripheral not shut down");
endmodule
bind swbs_sequencer swbs_checker #(.BOOT_FIXED_CYC(BOOT_FIXED_CYC), .BOOT_PER_KB_CYC(BOOT_PER_KB_CYC),
	.BOOT_KB(BOOT_KB)) u_chk (.clk(clk), .rstn(rstn), .gpio_in(gpio_in), .standby_req(standby_req),
	.periph_shutdown(periph_shutdown), .shutdown_all(shutdown_all), .otp_req(otp_req), .code_wr(code_wr),
	.mcu_reset_n(mcu_reset_n), .boot_busy(boot_busy), .in_standby(in_standby), .power(power), .periph_en(periph_en));

// *** sim/standby_wake_boot_sequencer_bench.sv ***
// Self-checking bench for the standby wake boot sequencer
`timescale 1ns/100ps
module standby_wake_boot_sequencer_bench
	import swbs_pkg::*;
;
	logic clk = 1'b0, rstn = 1'b0, sleep_enable = 1'b0, standby_req = 1'b0, rram_we = 1'b0;
	logic [8:0] gpio_in = 9'h1ff;
	logic [31:0] sleep_period = 32'h0000_0000;
	logic [2:0] sysclk_div_sel = 3'h0, rram_addr = 3'h0;
	logic [7:0] periph_shutdown = 8'h00, rram_wdata = 8'h00, otp_data, rram_rdata, periph_en;
	logic [6:0] misc = 7'h00;
	logic fcnt_start = 1'b0, fcnt_ref_tick = 1'b0, fcnt_meas_tick = 1'b0, fcnt_done;
	logic [15:0] fcnt_ref_len = 16'h0000;
	logic [23:0] fcnt_result;
	logic [19:0] expf[$];
	int k, meas;
	logic mcu_reset_n, boot_busy, in_standby, sysclk_tick;
	swbs_otp_req_s otp_req;
	swbs_code_wr_s code_wr;
	swbs_power_s power;
	int miscompares = 0, n_compared = 0, seed = 32'h2134, i, n;
	logic [19:0] expq[$];
	logic [7:0] saved[8];
	always #5 clk = ~clk;
	swbs_sequencer #(.BOOT_FIXED_CYC(20), .BOOT_PER_KB_CYC(4096), .BOOT_KB(1)) u_dut (
		.clk, .rstn, .gpio_in, .sleep_period, .sleep_enable, .standby_req, .otp_data, .sysclk_div_sel,
		.xtal_use(misc[0]), .tx_prepare(misc[1]), .serializer_carrier_on(misc[2]), .serializer_divider_on(misc[3]),
		.serializer_pa_on(misc[4]), .analog_in_use(misc[5]), .periph_shutdown, .shutdown_all(misc[6]),
		.fcnt_start, .fcnt_ref_tick, .fcnt_meas_tick, .fcnt_ref_len, .rram_we,
		.rram_addr, .rram_wdata, .rram_rdata, .otp_req, .code_wr, .mcu_reset_n, .boot_busy, .in_standby,
		.sysclk_tick, .power, .periph_en, .fcnt_result, .fcnt_done);
	swbs_otp_model u_otp (.clk, .otp_req, .otp_data);
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	// Every wake copies the full image, bytes in ascending order
	task automatic boot_expect;
		for (int a = 0; a < 1024; a++) expq.push_back({a[11:0], a[7:0] ^ a[11:4] ^ 8'h3c});
	endtask
	task automatic wait_run;
		n = 0;
		while (mcu_reset_n !== 1'b1 && n < 6000) begin
			cyc(1);
			n++;
		end
		if (n == 6000) begin
			miscompares++;
			close_out();
		end
		cyc(2);
		chk(20'(expq.size()), 20'h0_0000);
	endtask
	always @(negedge clk) begin
		if (rstn && code_wr.we === 1'b1) begin
			if (expq.size() == 0) chk(20'hf_ffff, {code_wr.addr, code_wr.data});
			else chk({code_wr.addr, code_wr.data}, expq.pop_front());
		end
		if (rstn && fcnt_done === 1'b1) begin
			if (expf.size() == 0) chk(20'hf_ffff, 20'(fcnt_result));
			else chk(20'(fcnt_result), expf.pop_front());
		end
	end
	initial begin
		misc = 7'($random(seed));
		periph_shutdown = 8'($random(seed));
		cyc(2);
		rstn = 1'b1;
		cyc(40);
		chk({18'h0_0000, in_standby, mcu_reset_n}, 20'h0_0002);
		boot_expect();
		i = ($random(seed) & 32'h7fff_ffff) % 9;
		gpio_in[i] = 1'b0;
		cyc(300);
		gpio_in = 9'h1fe;
		cyc(2);
		gpio_in = 9'h1ff;
		wait_run();
		chk({4'h0, periph_en, power.lp_osc_en, power.rtc_tmr_clk_en, power.xtal_en, power.carrier_en, power.divider_en,
			power.pa_en, power.bandgap_en, 1'b0}, {4'h0, ~periph_shutdown & ~{8{misc[6]}}, 2'b11, misc[0] & misc[1],
			misc[2] | (misc[0] & misc[1]), misc[3], misc[4], misc[5], 1'b0});
		// Sixteen reference ticks, one every fourth cycle, against random measured ticks
		fcnt_ref_len = 16'h0010;
		fcnt_start = 1'b1;
		cyc(1);
		fcnt_start = 1'b0;
		meas = 0;
		for (k = 1; k <= 64; k++) begin
			fcnt_ref_tick = (k % 4 == 0);
			fcnt_meas_tick = 1'($random(seed));
			meas += fcnt_meas_tick;
			if (k == 64) expf.push_back(20'(meas));
			cyc(1);
		end
		fcnt_ref_tick = 1'b0;
		fcnt_meas_tick = 1'b0;
		cyc(3);
		chk(20'(expf.size()), 20'h0_0000);
		for (i = 0; i < 8; i++) begin
			saved[i] = 8'($random(seed));
			rram_addr = i[2:0];
			rram_wdata = saved[i];
			rram_we = 1'b1;
			cyc(1);
		end
		rram_we = 1'b0;
		for (i = 0; i < 8; i++) begin
			sysclk_div_sel = i[2:0];
			cyc(16);
			n = 0;
			repeat (256) begin
				cyc(1);
				n += sysclk_tick;
			end
			chk({19'h0_0000, n >= (256 >> i) - 1 && n <= (256 >> i) + 1}, 20'h0_0001);
		end
		standby_req = 1'b1;
		cyc(1);
		standby_req = 1'b0;
		cyc(1);
		chk({18'h0_0000, in_standby, mcu_reset_n}, 20'h0_0002);
		boot_expect();
		sleep_period = 32'h0000_003c;
		sleep_enable = 1'b1;
		wait_run();
		sleep_enable = 1'b0;
		for (i = 0; i < 8; i++) begin
			rram_addr = i[2:0];
			#1;
			chk({12'h000, rram_rdata}, {12'h000, saved[i]});
		end
		close_out();
	end
endmodule
